// ===== shared/uart_cfg.svh
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// ****************************************
// clock, baud and frame timing
// ****************************************
`define UART_CLK_HZ 25000000
`define UART_DEF_BAUD 9600
`define UART_OVS 16
`define UART_DEF_DIV ((`UART_CLK_HZ + (`UART_DEF_BAUD * `UART_OVS) / 2) / (`UART_DEF_BAUD * `UART_OVS))
`define UART_OVS_LAST 4'hF
`define UART_OVS_MID 4'h7
`define UART_BRK_BITS 13
`define UART_BRK_TICKS (`UART_BRK_BITS * `UART_OVS)
`define UART_IRQ_CHARS 8
`define UART_RX_DEPTH 16
`define UART_RTS_MARGIN 2
`define UART_MIN_BITS 4'd5
`define UART_MAX_BITS 4'd9
`define UART_MIN_PRIO 3'h1

// ****************************************
// register map, byte addresses
// ****************************************
`define UART_CH_BIT 5
`define UART_OFS_CTRL 5'h00
`define UART_OFS_BAUD 5'h04
`define UART_OFS_DATA 5'h08
`define UART_OFS_STATUS 5'h0C
`define UART_OFS_ISTAT 5'h10
`define UART_OFS_IMASK 5'h14
`define UART_OFS_PRIO 5'h18

// ****************************************
// field positions and reset values
// ****************************************
`define UART_CTRL_RST 13'h0611
`define UART_ST_TXFULL 8
`define UART_ST_TXBUSY 9
`define UART_EV_RX 0
`define UART_EV_PAR 1
`define UART_EV_FRM 2

`endif

// ===== shared/uart_pkg.sv
package uart_pkg;

	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;

	// control register layout, top bit first, en at bit 0
	typedef struct packed {
		logic ctsPin;
		logic rtsPin;
		logic rxPin;
		logic txPin;
		logic brk;
		logic stop2;
		parity_t par;
		logic [3:0] nbits;
		logic en;
	} ctrl_t;

	// parity bit over the active data bits
	function automatic logic par_bit(logic [8:0] d, logic [3:0] nb,
		parity_t p);
		logic x;
		x = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < nb) begin
				x = x ^ d[i];
			end
		end
		return (p == PAR_ODD) ? ~x : x;
	endfunction

endpackage

// ===== shared/uart_ch_if.sv
`timescale 1ns/1ps
interface uart_ch_if #(parameter int DEPTH = 16);
	localparam int CW = $clog2(DEPTH) + 1;
	logic en;
	logic tick;
	logic [3:0] nbits;
	uart_pkg::parity_t par;
	logic stop2;
	logic brk;
	logic [8:0] txData;
	logic txValid;
	logic ctsBlock;
	logic txTake;
	logic txBusy;
	logic txLine;
	logic rxLine;
	logic rxPop;
	logic [8:0] rxData;
	logic [CW-1:0] rxCount;
	logic rxEvt;
	logic parErr;
	logic frmErr;

	modport tx (input en, tick, nbits, par, stop2, brk, txData, txValid,
		ctsBlock, output txTake, txBusy, txLine);
	modport rx (input en, tick, nbits, par, stop2, rxLine, rxPop,
		output rxData, rxCount, rxEvt, parErr, frmErr);
endinterface

// ===== hw/uart_tx.sv
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_tx (
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, low
	uart_ch_if.tx link // channel link
);
	import uart_pkg::*;

	typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP,
		T_BRK} txst_t;
	typedef struct packed {
		txst_t st;
		logic [3:0] ovs;
		logic [3:0] idx;
		logic [7:0] brkCnt;
		logic [8:0] shf;
		logic line;
		logic stopLeft;
	} tx_t;
	localparam tx_t TX_RST = '{st: T_IDLE, line: 1'b1, default: '0};

	tx_t s, n;
	logic bitEnd;

	assign link.txTake = link.en && s.st == T_IDLE && !link.brk &&
		link.txValid && !link.ctsBlock;
	assign link.txBusy = s.st != T_IDLE;
	assign link.txLine = s.line;

	always_comb begin
		n = s;
		bitEnd = link.tick && s.ovs == `UART_OVS_LAST;
		if (link.tick && s.st != T_IDLE) begin
			n.ovs = s.ovs + 4'h1;
		end
		if (!link.en) begin
			n = TX_RST;
		end else begin
			case (s.st)
			T_IDLE: begin
				n.line = 1'b1;
				n.ovs = '0;
				if (link.brk) begin
					n.st = T_BRK;
					n.brkCnt = '0;
					n.line = 1'b0;
				end else if (link.txTake) begin
					n.shf = link.txData;
					n.st = T_START;
					n.line = 1'b0;
				end
			end
			T_START: if (bitEnd) begin
				n.st = T_DATA;
				n.idx = '0;
				n.line = s.shf[0];
			end
			T_DATA: if (bitEnd) begin
				if (s.idx == link.nbits - 4'h1) begin
					if (link.par != PAR_NONE) begin
						n.st = T_PAR;
						n.line = par_bit(s.shf, link.nbits, link.par);
					end else begin
						n.st = T_STOP;
						n.line = 1'b1;
						n.stopLeft = link.stop2;
					end
				end else begin
					n.idx = s.idx + 4'h1;
					n.line = s.shf[s.idx + 4'h1];
				end
			end
			T_PAR: if (bitEnd) begin
				n.st = T_STOP;
				n.line = 1'b1;
				n.stopLeft = link.stop2;
			end
			T_STOP: if (bitEnd) begin
				if (s.stopLeft) begin
					n.stopLeft = 1'b0;
				end else begin
					n.st = T_IDLE;
				end
			end
			T_BRK: begin
				n.line = 1'b0;
				if (link.tick) begin
					n.brkCnt = s.brkCnt + 8'h1;
					if (s.brkCnt == 8'(`UART_BRK_TICKS - 1)) begin
						n.st = T_IDLE;
						n.line = 1'b1;
					end
				end
			end
			default: n = TX_RST;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= TX_RST;
		end else begin
			s <= n;
		end
	end
endmodule

// ===== hw/uart_rx.sv
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_rx #(
	parameter int DEPTH = `UART_RX_DEPTH // receive buffer words
) (
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, low
	uart_ch_if.rx link // channel link
);
	import uart_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rxst_t;
	typedef struct packed {
		rxst_t st;
		logic [3:0] ovs;
		logic [3:0] idx;
		logic [8:0] shf;
		logic perr;
		logic [DEPTH-1:0][8:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic [3:0] since;
		logic [7:0] silent;
		logic idleDone;
		logic evt;
		logic pe;
		logic fe;
	} rx_t;
	localparam rx_t RX_RST = '{st: R_IDLE, default: '0};

	rx_t s, n;
	logic sample;
	logic [7:0] frameTicks;

	assign link.rxData = s.mem[s.rp];
	assign link.rxCount = s.cnt;
	assign link.rxEvt = s.evt;
	assign link.parErr = s.pe;
	assign link.frmErr = s.fe;

	always_comb begin
		n = s;
		n.evt = 1'b0;
		n.pe = 1'b0;
		n.fe = 1'b0;
		sample = link.tick && s.ovs == `UART_OVS_LAST;
		frameTicks = 8'(`UART_OVS) * (8'h2 + 8'(link.nbits) +
			8'(link.par != PAR_NONE) + 8'(link.stop2));
		if (link.tick) begin
			n.ovs = s.ovs + 4'h1;
		end
		if (link.rxPop && s.cnt != '0) begin
			n.rp = s.rp + 1'b1;
			n.cnt = s.cnt - 1'b1;
		end
		// silence counted in ticks of the line staying idle
		if (s.st != R_IDLE || !link.rxLine) begin
			n.silent = '0;
		end else if (link.tick && s.silent != frameTicks) begin
			n.silent = s.silent + 8'h1;
		end
		if (s.silent == frameTicks && s.cnt != '0 && !s.idleDone) begin
			n.evt = 1'b1;
			n.idleDone = 1'b1;
			n.since = '0;
		end
		case (s.st)
		R_IDLE: if (!link.rxLine) begin
			n.st = R_START;
			n.ovs = '0;
			n.shf = '0;
		end
		R_START: if (link.tick && s.ovs == `UART_OVS_MID) begin
			n.ovs = '0;
			n.idx = '0;
			n.st = link.rxLine ? R_IDLE : R_DATA;
		end
		R_DATA: if (sample) begin
			n.shf[s.idx] = link.rxLine;
			n.idx = s.idx + 4'h1;
			if (s.idx == link.nbits - 4'h1) begin
				n.st = (link.par != PAR_NONE) ? R_PAR : R_STOP;
			end
		end
		R_PAR: if (sample) begin
			n.perr = link.rxLine != par_bit(s.shf, link.nbits, link.par);
			n.st = R_STOP;
		end
		R_STOP: if (sample) begin
			n.st = R_IDLE;
			n.fe = !link.rxLine;
			n.pe = (link.par != PAR_NONE) && s.perr;
			n.perr = 1'b0;
			n.idleDone = 1'b0;
			if (n.cnt != CW'(DEPTH)) begin
				n.mem[s.wp] = s.shf;
				n.wp = s.wp + 1'b1;
				n.cnt = n.cnt + 1'b1;
				n.since = s.since + 4'h1;
				if (s.since == 4'(`UART_IRQ_CHARS - 1)) begin
					n.evt = 1'b1;
					n.since = '0;
				end
			end
		end
		default: n.st = R_IDLE;
		endcase
		if (!link.en) begin
			n = RX_RST;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= RX_RST;
		end else begin
			s <= n;
		end
	end
endmodule

// ===== hw/uart_duo.sv
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_duo #(
	parameter int RX_DEPTH = `UART_RX_DEPTH // receive buffer words
) (
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, low
	input wire logic [7:0] wb_adr_i, // bus byte address
	input wire logic [31:0] wb_dat_i, // bus write data
	output logic [31:0] wb_dat_o, // bus read data
	input wire logic wb_we_i, // bus write
	input wire logic [3:0] wb_sel_i, // bus byte enables
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	output logic wb_ack_o, // bus acknowledge
	input wire logic [1:0] rxd, // serial receive pins
	input wire logic [1:0] ctsN, // clear to send, low active
	input wire logic sleepIdle, // system sits in idle state
	output logic [1:0] txd, // serial transmit pins
	output logic [1:0] rtsN, // request to send, low active
	output logic irq, // interrupt, high level
	output logic [2:0] irqPrio, // priority of pending interrupt
	output logic wakeIdle // wake request from idle
);
	import uart_pkg::*;

	localparam int NCH = 2;
	localparam int CW = $clog2(RX_DEPTH) + 1;

	if (RX_DEPTH < `UART_IRQ_CHARS || RX_DEPTH > 128 ||
		(RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_chk
		$error("RX_DEPTH must be a power of two from 8 to 128");
	end

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		ctrl_t ctrl;
		logic [15:0] div;
		logic [15:0] divCnt;
		logic tick;
		logic pop;
		logic [1:0] rxSync;
		logic [1:0] ctsSync;
		logic [8:0] txHold;
		logic txFull;
		logic [2:0] stat;
		logic [2:0] mask;
		logic [2:0] prio;
		logic txd;
		logic rtsN;
	} chan_t;
	typedef struct packed {
		chan_t [NCH-1:0] ch;
		logic ack;
		logic [31:0] dat;
		logic irq;
		logic [2:0] prio;
		logic wake;
	} state_t;

	localparam chan_t CH_RST = '{ctrl: `UART_CTRL_RST,
		div: 16'(`UART_DEF_DIV), prio: `UART_MIN_PRIO,
		rxSync: 2'h3, txd: 1'b1, default: '0};
	localparam state_t ST_RST = '{ch: {NCH{CH_RST}}, default: '0};

	state_t s, n;

	logic txTake [NCH];
	logic txBusy [NCH];
	logic txLine [NCH];
	logic [8:0] rxData [NCH];
	logic [CW-1:0] rxCount [NCH];
	logic [2:0] ev [NCH];

	// byte-lane merge of a write into a register word
	function automatic logic [31:0] wmerge(logic [31:0] old,
		logic [31:0] wr, logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = wr[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************
	// channels
	// ****************************************
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		uart_ch_if #(.DEPTH(RX_DEPTH)) link();
		assign link.en = s.ch[i].ctrl.en;
		assign link.tick = s.ch[i].tick;
		assign link.nbits = s.ch[i].ctrl.nbits;
		assign link.par = s.ch[i].ctrl.par;
		assign link.stop2 = s.ch[i].ctrl.stop2;
		assign link.brk = s.ch[i].ctrl.brk;
		assign link.txData = s.ch[i].txHold;
		assign link.txValid = s.ch[i].txFull;
		assign link.ctsBlock = s.ch[i].ctrl.ctsPin && s.ch[i].ctrl.rxPin &&
			s.ch[i].ctsSync[1];
		assign link.rxLine = s.ch[i].ctrl.rxPin ? s.ch[i].rxSync[1] : 1'b1;
		assign link.rxPop = s.ch[i].pop;
		assign txTake[i] = link.txTake;
		assign txBusy[i] = link.txBusy;
		assign txLine[i] = link.txLine;
		assign rxData[i] = link.rxData;
		assign rxCount[i] = link.rxCount;
		assign ev[i] = {link.frmErr, link.parErr, link.rxEvt};

		uart_tx u_tx (
			.mclk(mclk),
			.nrst(nrst),
			.link(link.tx)
		);
		uart_rx #(.DEPTH(RX_DEPTH)) u_rx (
			.mclk(mclk),
			.nrst(nrst),
			.link(link.rx)
		);
	end

	// ****************************************
	// next state
	// ****************************************
	logic c;
	logic [4:0] ofs;
	logic [31:0] wv;
	logic [31:0] rd;
	ctrl_t nc;
	logic [2:0] pend;

	always_comb begin
		n = s;
		c = wb_adr_i[`UART_CH_BIT];
		ofs = wb_adr_i[4:0];
		wv = '0;
		rd = '0;
		nc = s.ch[c].ctrl;
		pend = '0;
		n.ack = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			n.ch[i].tick = 1'b0;
			n.ch[i].pop = 1'b0;
			n.ch[i].ctrl.brk = 1'b0;
			n.ch[i].rxSync = {s.ch[i].rxSync[0], rxd[i]};
			n.ch[i].ctsSync = {s.ch[i].ctsSync[0], ctsN[i]};
			if (!s.ch[i].ctrl.en) begin
				n.ch[i].divCnt = '0;
				n.ch[i].txFull = 1'b0;
			end else if (s.ch[i].divCnt + 16'h1 >= s.ch[i].div) begin
				n.ch[i].divCnt = '0;
				n.ch[i].tick = 1'b1;
			end else begin
				n.ch[i].divCnt = s.ch[i].divCnt + 16'h1;
			end
			if (txTake[i]) begin
				n.ch[i].txFull = 1'b0;
			end
		end
		// bus slave, one wait state, acts on the edge that raises ack
		if (wb_cyc_i && wb_stb_i && !s.ack) begin
			n.ack = 1'b1;
			if (wb_adr_i[7:6] != 2'h0) begin
				rd = '0;
			end else if (ofs == `UART_OFS_CTRL) begin
				rd = 32'(s.ch[c].ctrl);
				wv = wmerge(rd, wb_dat_i, wb_sel_i);
				if (wb_we_i) begin
					nc = ctrl_t'(wv[$bits(ctrl_t)-1:0]);
					if (nc.nbits < `UART_MIN_BITS ||
						nc.nbits > `UART_MAX_BITS) begin
						nc.nbits = s.ch[c].ctrl.nbits;
					end
					if (nc.par != PAR_EVEN && nc.par != PAR_ODD) begin
						nc.par = PAR_NONE;
					end
					nc.brk = nc.brk && nc.en && nc.txPin;
					n.ch[c].ctrl = nc;
				end
			end else if (ofs == `UART_OFS_BAUD) begin
				rd = 32'(s.ch[c].div);
				wv = wmerge(rd, wb_dat_i, wb_sel_i);
				if (wb_we_i) begin
					n.ch[c].div = (wv[15:0] == '0) ? 16'h1 : wv[15:0];
				end
			end else if (ofs == `UART_OFS_DATA) begin
				rd = 32'(rxData[c]);
				if (wb_we_i) begin
					if (!s.ch[c].txFull && s.ch[c].ctrl.en) begin
						n.ch[c].txHold = wb_dat_i[8:0];
						n.ch[c].txFull = 1'b1;
					end
				end else begin
					n.ch[c].pop = rxCount[c] != '0;
				end
			end else if (ofs == `UART_OFS_STATUS) begin
				rd[7:0] = 8'(rxCount[c]);
				rd[`UART_ST_TXFULL] = s.ch[c].txFull;
				rd[`UART_ST_TXBUSY] = txBusy[c];
			end else if (ofs == `UART_OFS_ISTAT) begin
				rd = 32'(s.ch[c].stat);
				if (wb_we_i && wb_sel_i[0]) begin
					n.ch[c].stat = s.ch[c].stat & ~wb_dat_i[2:0];
				end
			end else if (ofs == `UART_OFS_IMASK) begin
				rd = 32'(s.ch[c].mask);
				if (wb_we_i && wb_sel_i[0]) begin
					n.ch[c].mask = wb_dat_i[2:0];
				end
			end else if (ofs == `UART_OFS_PRIO) begin
				rd = 32'(s.ch[c].prio);
				if (wb_we_i && wb_sel_i[0]) begin
					n.ch[c].prio = (wb_dat_i[2:0] == 3'h0) ?
						`UART_MIN_PRIO : wb_dat_i[2:0];
				end
			end else begin
				rd = '0;
			end
			n.dat = rd;
		end
		// events set after the clear so a simultaneous event survives
		n.irq = 1'b0;
		n.prio = '0;
		for (int i = 0; i < NCH; i++) begin
			n.ch[i].stat = n.ch[i].stat | ev[i];
			pend = n.ch[i].stat & n.ch[i].mask;
			if (pend != '0) begin
				n.irq = 1'b1;
				if (n.ch[i].prio > n.prio) begin
					n.prio = n.ch[i].prio;
				end
			end
			n.ch[i].txd = (n.ch[i].ctrl.en && n.ch[i].ctrl.txPin) ?
				txLine[i] : 1'b1;
			n.ch[i].rtsN = n.ch[i].ctrl.rtsPin && n.ch[i].ctrl.rxPin &&
				32'(rxCount[i]) >= RX_DEPTH - `UART_RTS_MARGIN;
		end
		n.wake = n.irq && sleepIdle;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= ST_RST;
		end else begin
			s <= n;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.dat;
	assign irq = s.irq;
	assign irqPrio = s.prio;
	assign wakeIdle = s.wake;
	for (genvar i = 0; i < NCH; i++) begin : g_pin
		assign txd[i] = s.ch[i].txd;
		assign rtsN[i] = s.ch[i].rtsN;
	end
endmodule

// ===== tb/uart_duo_chk.sv
`timescale 1ns/1ps
module uart_duo_chk #(
	parameter int RX_DEPTH = 16 // receive buffer words
) (
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, low
	input wire logic [7:0] wb_adr_i, // bus address
	input wire logic [31:0] wb_dat_i, // bus write data
	input wire logic [31:0] wb_dat_o, // bus read data
	input wire logic wb_we_i, // bus write
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_ack_o, // bus acknowledge
	input wire logic [1:0] rxd, // serial inputs
	input wire logic [1:0] ctsN, // clear to send, low
	input wire logic sleepIdle, // system idle
	input wire logic [1:0] txd, // serial outputs
	input wire logic [1:0] rtsN, // request to send, low
	input wire logic irq, // interrupt
	input wire logic [2:0] irqPrio, // pending priority
	input wire logic wakeIdle // wake request
);
	// ****************************************
	// low run length of channel 0 line
	// ****************************************
	localparam int BRK = 208; // break span with divider one
	logic [8:0] lowCnt_r;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			lowCnt_r <= 9'h000;
		else if (txd[0])
			lowCnt_r <= 9'h000;
		else if (lowCnt_r != 9'h1FF)
			lowCnt_r <= lowCnt_r + 9'h001;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_prio_set: assert property (irq |-> irqPrio != 3'h0)
		else $error("pending interrupt without priority");
	a_prio_none: assert property (!irq |-> irqPrio == 3'h0)
		else $error("priority shown without interrupt");
	a_wake_idle: assert property (wakeIdle |-> $past(sleepIdle) && (irq || $past(irq)))
		else $error("wake outside idle state");
	a_irq_clear: assert property ($fell(irq) |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
		else $error("interrupt dropped without a write");
	a_start_bit: assert property ($fell(txd[0]) |=> !txd[0] [*8])
		else $error("start bit too short");
	a_break_len: assert property ($rose(txd[0]) && lowCnt_r > 9'd192 |-> lowCnt_r >= 9'(BRK - 2) && lowCnt_r <= 9'(BRK + 2))
		else $error("break length wrong");
	a_break_cap: assert property (lowCnt_r <= 9'(BRK + 2))
		else $error("line held low too long");
	cover property ($rose(irq));
	cover property ($rose(txd[0]) && lowCnt_r > 9'd192);
	cover property (wakeIdle);
	cover property (rtsN[0]);
endmodule
bind uart_duo uart_duo_chk #(.RX_DEPTH(RX_DEPTH)) uart_duo_chk_inst (
	.mclk(mclk), .nrst(nrst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.rxd(rxd), .ctsN(ctsN), .sleepIdle(sleepIdle), .txd(txd), .rtsN(rtsN),
	.irq(irq), .irqPrio(irqPrio), .wakeIdle(wakeIdle)
);

// ===== tb/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
	input wire logic mclk, // system clock
	input wire logic line, // line from the block
	output logic rxOut // line into the block
);
	// ****************************************
	// remote serial device, bc cycles a bit
	// ****************************************
	initial rxOut = 1'b1;
	task automatic send(input logic [7:0] v, input int bc);
		@(posedge mclk);
		rxOut <= 1'b0;
		repeat (bc) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			rxOut <= v[i];
			repeat (bc) @(posedge mclk);
		end
		rxOut <= 1'b1;
		repeat (bc) @(posedge mclk);
	endtask
	// samples at bit centres, off the clock edge
	task automatic recv(input int nb, input int par, input int st,
		input int bc, output logic [8:0] v, output logic p, output logic ok);
		v = 9'h000;
		p = 1'b0;
		@(negedge line);
		repeat (bc / 2) @(negedge mclk);
		ok = !line;
		for (int i = 0; i < nb; i++) begin
			repeat (bc) @(negedge mclk);
			v[i] = line;
		end
		if (par != 0) begin
			repeat (bc) @(negedge mclk);
			p = line;
		end
		for (int i = 0; i < st; i++) begin
			repeat (bc) @(negedge mclk);
			ok = ok && line;
		end
	endtask
endmodule

// ===== tb/test_uart_duo.sv
`timescale 1ns/1ps
module test_uart_duo;
	logic mclk, nrst, wb_we_i, wb_cyc_i, wb_stb_i, sleepIdle;
	logic wb_ack_o, irq, wakeIdle, p, ok;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [3:0] wb_sel_i;
	logic [1:0] ctsN, txd, rtsN;
	wire [1:0] rxd;
	logic [2:0] irqPrio;
	logic [8:0] d, e;
	logic [7:0] rxQ[$];
	logic [7:0] rA[5] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1C};
	logic [31:0] rV[5] = '{32'h611, 32'hA3, 32'h0, 32'h1, 32'h0};
	int bad_count, n_compared, seed, nb, pr, st;
	uart_duo #(.RX_DEPTH(16)) uart_duo_inst (
		.mclk(mclk), .nrst(nrst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
		.rxd(rxd), .ctsN(ctsN), .sleepIdle(sleepIdle), .txd(txd), .rtsN(rtsN),
		.irq(irq), .irqPrio(irqPrio), .wakeIdle(wakeIdle));
	serial_peer peer0 (.mclk(mclk), .line(txd[0]), .rxOut(rxd[0]));
	serial_peer peer1 (.mclk(mclk), .line(txd[1]), .rxOut(rxd[1]));
	// ****************************************
	// clock, checks and bus cycles
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic complete_run;
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		complete_run;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until the rising edge that samples ack high
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
		@(posedge mclk);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= v;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus(a, 1'b1, v);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		bus(a, 1'b0, 32'h0);
		chk(q, x);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		seed = 32'hDC1AE5B2;
		{nrst, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hF;
		sleepIdle = 1'b1;
		ctsN = 2'b00;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		foreach (rA[i]) rd(rA[i], rV[i]);
		chk(32'({txd, rtsN, irq}), 32'h18);
		wr(8'h04, 32'h1);
		wr(8'h24, 32'h1);
		wr(8'h14, 32'h1);
		wr(8'h18, 32'h5);
		for (int k = 0; k < 5; k++) begin
			nb = 5 + k;
			pr = k % 3;
			st = k % 2;
			e = 9'($random(seed)) & 9'((1 << nb) - 1);
			wr(8'h00, 32'(1 | nb << 1 | pr << 5 | st << 7 | 32'h600));
			fork
				peer0.recv(nb, pr, st + 1, 16, d, p, ok);
				wr(8'h08, 32'(e));
			join
			chk(d, e);
			if (pr != 0) chk(p, ^e ^ (pr == 2));
			chk(ok, 1);
		end
		wr(8'h00, 32'h1E11);
		ctsN <= 2'b01;
		fork
			peer0.recv(8, 0, 1, 16, d, p, ok);
			begin
				wr(8'h08, 32'hA5);
				repeat (60) @(posedge mclk);
				chk(txd[0], 1);
				ctsN <= 2'b00;
			end
		join
		chk(d, 9'hA5);
		for (int i = 0; i < 14; i++) begin
			rxQ.push_back(8'($random(seed)));
			peer0.send(rxQ[i], 16);
			if (i == 6) chk(irq, 0);
			if (i == 7) begin
				repeat (4) @(posedge mclk);
				chk({irq, irqPrio, wakeIdle}, 5'h1B);
			end
		end
		repeat (4) @(posedge mclk);
		chk(rtsN[0], 1);
		rd(8'h0C, 32'hE);
		while (rxQ.size() > 0) rd(8'h08, rxQ.pop_front());
		chk(rtsN[0], 0);
		wr(8'h10, 32'h1);
		repeat (2) @(posedge mclk);
		chk(irq, 0);
		sleepIdle <= 1'b0;
		peer0.send(8'h3C, 16);
		repeat (140) @(posedge mclk);
		chk(irq, 0);
		repeat (40) @(posedge mclk);
		chk({irq, wakeIdle}, 2'b10);
		rd(8'h08, 32'h3C);
		wr(8'h10, 32'h1);
		peer1.send(8'h5A, 16);
		rd(8'h2C, 32'h1);
		rd(8'h0C, 32'h0);
		rd(8'h28, 32'h5A);
		wr(8'h00, 32'h711);
		repeat (100) @(posedge mclk);
		chk(txd[0], 0);
		repeat (120) @(posedge mclk);
		chk(txd[0], 1);
		wr(8'h00, 32'h610);
		wr(8'h08, 32'h55);
		rd(8'h0C, 32'h0);
		chk(txd[0], 1);
		complete_run;
	end
endmodule
